// >>> design/dbfu_bridge.v
`include "dbfu_regs.vh"

module dbfu_bridge (
	// clock and reset
	input wire ref_clk,
	input wire rst_b,
	// master side, address phase
	input wire [1:0] m_htrans,
	input wire [31:0] m_haddr,
	input wire m_hwrite,
	input wire [2:0] m_hsize,
	input wire [3:0] m_hprot,
	// master side, data phase
	input wire [31:0] m_hwdata,
	output reg [31:0] m_hrdata,
	output reg m_hready,
	output reg m_hresp,
	// slave side, address phase
	output reg [1:0] s_htrans,
	output reg [31:0] s_haddr,
	output reg s_hwrite,
	output reg [2:0] s_hsize,
	output reg [3:0] s_hprot,
	// slave side, data phase
	output reg [31:0] s_hwdata,
	input wire [31:0] s_hrdata,
	input wire peripheral_ready,
	input wire s_hresp
);

	// ----------------------------------------
	// state and captured request
	// ----------------------------------------
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [2:0] op_q;
	reg [31:0] addr_q;
	reg [2:0] size_q;
	reg [3:0] prot_q;
	reg [4:0] lsb_q;
	reg [3:0] wm1_q;
	reg [31:0] masked_q;
	reg [31:0] wdata_q;

	// ----------------------------------------
	// decode of the incoming address phase
	// ----------------------------------------
	wire in_region;
	wire is_insert;
	wire is_extract;
	wire is_clear;
	wire is_set;
	wire addr_open;
	wire take;
	reg [2:0] dec_op;
	reg [31:0] real_addr;
	reg [4:0] dec_lsb;
	reg [3:0] dec_wm1;
	wire [31:0] fu_masked;
	wire [31:0] fu_wr_data;
	wire [31:0] fu_rd_data;
	wire slave_write_access;

	// decorated window: top bits match and an op code is present
	assign in_region =
		(m_haddr[`DBFU_REGION_HI:`DBFU_REGION_LO] == `DBFU_REGION_VAL) &&
		(m_haddr[`DBFU_OP_HI:`DBFU_OP_LO] != `DBFU_OP_NONE_CODE);

	// op selection from bit 28 and the load codes
	assign is_insert = in_region && m_hwrite &&
		m_haddr[`DBFU_FIELD_BIT];
	assign is_extract = in_region && !m_hwrite &&
		m_haddr[`DBFU_FIELD_BIT];
	assign is_clear = in_region && !m_hwrite &&
		(m_haddr[`DBFU_OP_HI:`DBFU_OP_LO] == `DBFU_LAC_CODE);
	assign is_set = in_region && !m_hwrite &&
		(m_haddr[`DBFU_OP_HI:`DBFU_OP_LO] == `DBFU_LAS_CODE);

	// new address phases are only looked at outside the first data phase
	assign addr_open = (state_q != `DBFU_ST_DP1);
	assign take = addr_open && m_htrans[1] && peripheral_ready;

	// op code, fields and stripped address of the request
	always @* begin
		dec_op = `DBFU_OPC_NONE;
		real_addr = m_haddr;
		dec_lsb = m_haddr[`DBFU_FLD_B_HI:`DBFU_FLD_B_LO];
		dec_wm1 = m_haddr[`DBFU_FLD_W_HI:`DBFU_FLD_W_LO];
		if (is_insert || is_extract) begin
			dec_op = is_insert ? `DBFU_OPC_INSERT : `DBFU_OPC_EXTRACT;
			real_addr = m_haddr & `DBFU_FLD_ADDR_MASK;
		end else if (is_clear || is_set) begin
			dec_op = is_set ? `DBFU_OPC_SET : `DBFU_OPC_CLEAR;
			real_addr = m_haddr & `DBFU_BIT_ADDR_MASK;
			dec_lsb = m_haddr[`DBFU_BIT_B_HI:`DBFU_BIT_B_LO];
			dec_wm1 = 4'h0;
		end
	end

	// ----------------------------------------
	// field arithmetic
	// ----------------------------------------
	dbfu_field_unit u_field (
		.op(op_q),
		.size(size_q),
		.lane(addr_q[1:0]),
		.lsb(lsb_q),
		.wm1(wm1_q),
		.rdata(s_hrdata),
		.wdata(m_hwdata),
		.masked_in(masked_q),
		.masked(fu_masked),
		.wr_data(fu_wr_data),
		.rd_data(fu_rd_data)
	);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------

	// next state: one stall phase, then the returning phase
	always @* begin
		state_d = state_q;
		case (state_q)
		`DBFU_ST_PASS: begin
			if (take && dec_op != `DBFU_OPC_NONE)
				state_d = `DBFU_ST_DP1;
		end
		`DBFU_ST_DP1: begin
			if (peripheral_ready)
				state_d = `DBFU_ST_DP2;
		end
		`DBFU_ST_DP2: begin
			if (peripheral_ready)
				state_d = (take && dec_op != `DBFU_OPC_NONE) ?
					`DBFU_ST_DP1 : `DBFU_ST_PASS;
		end
		default: state_d = `DBFU_ST_PASS;
		endcase
	end

	// state register
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			state_q <= `DBFU_ST_PASS;
		else
			state_q <= state_d;
	end

	// capture of address and attributes in cycle x
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			op_q <= `DBFU_OPC_NONE;
			addr_q <= 32'h00000000;
			size_q <= `DBFU_SIZE_BYTE;
			prot_q <= 4'h0;
			lsb_q <= 5'h00;
			wm1_q <= 4'h0;
		end else if (take) begin
			op_q <= dec_op;
			addr_q <= real_addr;
			size_q <= m_hsize;
			prot_q <= m_hprot;
			lsb_q <= dec_lsb;
			wm1_q <= dec_wm1;
		end
	end

	// first data phase: register the modified word and the masked field
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			masked_q <= 32'h00000000;
			wdata_q <= 32'h00000000;
		end else if (state_q == `DBFU_ST_DP1 && peripheral_ready) begin
			masked_q <= fu_masked;
			wdata_q <= fu_wr_data;
		end
	end

	// ----------------------------------------
	// slave side drive
	// ----------------------------------------

	// address phase: forwarded, stripped, recirculated or idle
	always @* begin
		s_htrans = m_htrans;
		s_haddr = m_haddr;
		s_hwrite = m_hwrite;
		s_hsize = m_hsize;
		s_hprot = m_hprot;
		if (state_q == `DBFU_ST_DP1) begin
			s_haddr = addr_q;
			s_hsize = size_q;
			s_hprot = prot_q;
			s_hwrite = 1'b1;
			if (op_q == `DBFU_OPC_EXTRACT) begin
				s_htrans = `DBFU_TRANS_IDLE;
				s_hwrite = 1'b0;
			end else begin
				s_htrans = `DBFU_TRANS_NONSEQ;
			end
		end else if (dec_op != `DBFU_OPC_NONE) begin
			s_haddr = real_addr;
			s_hwrite = 1'b0;
		end
	end

	// write flag of the slave data phase in progress
	assign slave_write_access = (state_q == `DBFU_ST_DP2) &&
		(op_q != `DBFU_OPC_EXTRACT);

	// slave write data: registered result or the master's data
	always @* begin
		if (slave_write_access)
			s_hwdata = wdata_q;
		else
			s_hwdata = m_hwdata;
	end

	// ----------------------------------------
	// master side answer
	// ----------------------------------------

	// ready, response and read data back to the master
	always @* begin
		m_hready = peripheral_ready;
		m_hresp = s_hresp;
		m_hrdata = s_hrdata;
		case (state_q)
		`DBFU_ST_DP1: begin
			m_hready = 1'b0;
			m_hresp = `DBFU_RESP_OKAY;
		end
		`DBFU_ST_DP2: begin
			if (op_q == `DBFU_OPC_INSERT)
				m_hrdata = 32'h00000000;
			else
				m_hrdata = fu_rd_data;
		end
		default: begin
			m_hready = peripheral_ready;
		end
		endcase
	end

endmodule

// >>> design/dbfu_field_unit.v
`include "dbfu_regs.vh"

module dbfu_field_unit (
	// operation
	input wire [2:0] op,
	input wire [2:0] size,
	input wire [1:0] lane,
	input wire [4:0] lsb,
	input wire [3:0] wm1,
	// data
	input wire [31:0] rdata,
	input wire [31:0] wdata,
	input wire [31:0] masked_in,
	// results
	output reg [31:0] masked,
	output reg [31:0] wr_data,
	output reg [31:0] rd_data
);

	reg [31:0] cmask;
	reg [4:0] pmask;
	reg [4:0] pos;
	reg [4:0] shamt;
	reg [31:0] cont;
	reg [31:0] wcont;
	reg [31:0] fmask;
	reg [31:0] newc;
	reg [32:0] ones;
	reg [31:0] ret;

	// container select, mask build and modify
	always @* begin
		cmask = 32'hFFFFFFFF;
		pmask = 5'h1F;
		shamt = 5'h00;
		case (size)
		`DBFU_SIZE_BYTE: begin
			cmask = 32'h000000FF;
			pmask = 5'h07;
			shamt = {lane, 3'h0};
		end
		`DBFU_SIZE_HALF: begin
			cmask = 32'h0000FFFF;
			pmask = 5'h0F;
			shamt = {lane[1], 4'h0};
		end
		default: begin
			cmask = 32'hFFFFFFFF;
			pmask = 5'h1F;
			shamt = 5'h00;
		end
		endcase
		// position bits above the container are don't-care
		pos = lsb & pmask;
		cont = (rdata >> shamt) & cmask;
		wcont = (wdata >> shamt) & cmask;
		ones = (33'h000000001 << ({1'b0, wm1} + 5'h01)) - 33'h000000001;
		if (op == `DBFU_OPC_INSERT || op == `DBFU_OPC_EXTRACT)
			fmask = (ones[31:0] << pos) & cmask;
		else
			fmask = (32'h00000001 << pos) & cmask;
		case (op)
		`DBFU_OPC_INSERT: newc = (cont & ~fmask) | (wcont & fmask);
		`DBFU_OPC_CLEAR: newc = cont & ~fmask;
		`DBFU_OPC_SET: newc = cont | fmask;
		default: newc = cont;
		endcase
		masked = cont & fmask;
		ret = masked_in >> pos;
		case (size)
		`DBFU_SIZE_BYTE: begin
			wr_data = {4{newc[7:0]}};
			rd_data = {4{ret[7:0]}};
		end
		`DBFU_SIZE_HALF: begin
			wr_data = {2{newc[15:0]}};
			rd_data = {2{ret[15:0]}};
		end
		default: begin
			wr_data = newc;
			rd_data = ret;
		end
		endcase
	end

endmodule

// >>> design/dbfu_regs.vh
// Notes on behaviour
// - store with address bit 28 is insert
// - insert lsb 27:23, width-1 22:19
// - insert offset 18:0, mask E007FFFF
// - insert uses bits 22:19 plus one as width
// - mask w+1 ones at lsb, merge
// - overflowing field bits beyond container dropped
// - insert: read, merge, then write
// - set/clear bit is two-cycle atomic
// - decorated load reads stripped address first
// - set/clear: write phase, register, stall
// - set/clear: return bit, drive write
// - extract reads only, stalls one cycle
// - extract second address phase is idle
// - extract masks read data, registers, stalls
// - extract shifts field down, returns it
// - slave wait states pass to master
// - load codes 010 clear, 011 set
`ifndef DBFU_REGS_VH
`define DBFU_REGS_VH

// ----------------------------------------
// decoration fields of the address
// ----------------------------------------
`define DBFU_REGION_HI 31
`define DBFU_REGION_LO 29
`define DBFU_REGION_VAL 3'h2
`define DBFU_OP_HI 28
`define DBFU_OP_LO 26
`define DBFU_OP_NONE_CODE 3'h0
`define DBFU_FIELD_BIT 28
`define DBFU_FLD_B_HI 27
`define DBFU_FLD_B_LO 23
`define DBFU_FLD_W_HI 22
`define DBFU_FLD_W_LO 19
`define DBFU_BIT_B_HI 25
`define DBFU_BIT_B_LO 21
`define DBFU_LAC_CODE 3'h2
`define DBFU_LAS_CODE 3'h3
`define DBFU_FLD_ADDR_MASK 32'hE007FFFF
`define DBFU_BIT_ADDR_MASK 32'hE00FFFFF

// ----------------------------------------
// internal operation codes
// ----------------------------------------
`define DBFU_OPC_NONE 3'h0
`define DBFU_OPC_INSERT 3'h1
`define DBFU_OPC_EXTRACT 3'h2
`define DBFU_OPC_CLEAR 3'h3
`define DBFU_OPC_SET 3'h4

// ----------------------------------------
// sequencer states
// ----------------------------------------
`define DBFU_ST_PASS 2'h0
`define DBFU_ST_DP1 2'h1
`define DBFU_ST_DP2 2'h2

// ----------------------------------------
// bus encodings
// ----------------------------------------
`define DBFU_TRANS_IDLE 2'h0
`define DBFU_TRANS_NONSEQ 2'h2
`define DBFU_SIZE_BYTE 3'h0
`define DBFU_SIZE_HALF 3'h1
`define DBFU_SIZE_WORD 3'h2
`define DBFU_RESP_OKAY 1'h0

`endif

// >>> verification/dbfu_bridge_monitor.sv
module dbfu_bridge_monitor (
	// clock and reset
	input wire ref_clk,
	input wire rst_b,
	// master side
	input wire [1:0] m_htrans,
	input wire [31:0] m_haddr,
	input wire m_hwrite,
	input wire [2:0] m_hsize,
	input wire [3:0] m_hprot,
	input wire m_hready,
	input wire m_hresp,
	// slave side
	input wire [1:0] s_htrans,
	input wire [31:0] s_haddr,
	input wire s_hwrite,
	input wire [2:0] s_hsize,
	input wire [3:0] s_hprot,
	input wire peripheral_ready
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// accepted decorated requests
	wire dec = m_htrans[1] && m_hready && m_haddr[31:29] == 3'h2;
	wire ins = dec && m_hwrite && m_haddr[28];
	wire ext = dec && !m_hwrite && m_haddr[28];
	wire sc = dec && !m_hwrite && m_haddr[28:27] == 2'h1;
	// write-back address phase with master stalled
	sequence recirc_s;
		s_hwrite && s_htrans == 2'h2 && !m_hready;
	endsequence
	ins_strip_a: assert property (
		ins |-> !s_hwrite && s_haddr == (m_haddr & 32'hE007FFFF))
		else $error("insert address wrong");
	ins_recirc_a: assert property (
		ins |=> recirc_s ##0 s_haddr == ($past(m_haddr) & 32'hE007FFFF))
		else $error("insert write phase wrong");
	bit_strip_a: assert property (
		sc |-> !s_hwrite && s_haddr == (m_haddr & 32'hE00FFFFF))
		else $error("bit load address wrong");
	bit_recirc_a: assert property (
		sc |=> recirc_s ##0 s_haddr == ($past(m_haddr) & 32'hE00FFFFF))
		else $error("bit write phase wrong");
	ext_idle_a: assert property (
		ext |=> s_htrans == 2'h0 && !m_hready)
		else $error("extract second phase not idle");
	wait_pass_a: assert property (
		!peripheral_ready |-> !m_hready)
		else $error("slave wait not passed");
	size_keep_a: assert property (
		(ins || sc) |-> s_hsize == m_hsize ##1 s_hsize == $past(m_hsize))
		else $error("access size changed");
	atomic_hold_a: assert property (
		(ins || sc || ext) |=> !m_hready)
		else $error("new transfer taken mid sequence");
	attr_keep_a: assert property (
		(ins || sc) |=> s_hprot == $past(m_hprot))
		else $error("attributes not recirculated");
	stall_okay_a: assert property (
		(ins || sc || ext) |=> m_hresp == 1'h0)
		else $error("stall cycle response not okay");
endmodule
bind dbfu_bridge dbfu_bridge_monitor dbfu_bridge_monitor_inst (.ref_clk,
	.rst_b, .m_htrans, .m_haddr, .m_hwrite, .m_hsize, .m_hprot, .m_hready,
	.m_hresp, .s_htrans, .s_haddr, .s_hwrite, .s_hsize, .s_hprot,
	.peripheral_ready);

// >>> verification/dbfu_slave_model.sv
module dbfu_slave_model (
	// clock and reset
	input wire ref_clk,
	input wire rst_b,
	// bus from the bridge
	input wire [1:0] s_htrans,
	input wire [31:0] s_haddr,
	input wire s_hwrite,
	input wire [31:0] s_hwdata,
	output logic [31:0] s_hrdata,
	output logic peripheral_ready,
	output logic s_hresp,
	// wait states per data phase
	input wire [3:0] waits
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] mem [0:15];
	logic dp_v, dp_w;
	logic [3:0] dp_a, wc;
	logic [31:0] cyc;
	// waits stretch each data phase; junk when no data is due
	assign peripheral_ready = !(dp_v && wc != 4'h0);
	assign s_hrdata = (dp_v && !dp_w && peripheral_ready) ? mem[dp_a] : cyc;
	assign s_hresp = 1'h0;
	// pipelined address and data phases
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dp_v <= 1'h0;
			wc <= 4'h0;
			cyc <= 32'h0;
		end else begin
			cyc <= ~cyc + 32'h3;
			if (peripheral_ready) begin
				if (dp_v && dp_w)
					mem[dp_a] <= s_hwdata;
				dp_v <= s_htrans[1];
				dp_w <= s_hwrite;
				dp_a <= s_haddr[5:2];
				wc <= waits;
			end else
				wc <= wc - 4'h1;
		end
	end
endmodule

// >>> verification/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ----
	// signals
	// ----
	logic ref_clk = 1'h0, rst_b = 1'h0, m_hwrite = 1'h0;
	logic [1:0] m_htrans = 2'h0, s_htrans;
	logic [2:0] m_hsize = 3'h2, s_hsize;
	logic [3:0] m_hprot = 4'h3, s_hprot, waits = 4'h0;
	logic [31:0] m_haddr = '0, m_hwdata = '0, m_hrdata, s_haddr, s_hwdata;
	logic [31:0] s_hrdata, rd;
	logic m_hready, m_hresp, s_hwrite, peripheral_ready, s_hresp;
	int num_errors = 0, tests_run = 0, cycles = 0;
	always #12.5 ref_clk = ~ref_clk;
	dbfu_bridge dbfu_bridge_inst (.ref_clk, .rst_b, .m_htrans, .m_haddr,
		.m_hwrite, .m_hsize, .m_hprot, .m_hwdata, .m_hrdata, .m_hready,
		.m_hresp, .s_htrans, .s_haddr, .s_hwrite, .s_hsize, .s_hprot,
		.s_hwdata, .s_hrdata, .peripheral_ready, .s_hresp);
	dbfu_slave_model dbfu_slave_model_inst (.ref_clk, .rst_b, .s_htrans,
		.s_haddr, .s_hwrite, .s_hwdata, .s_hrdata, .peripheral_ready,
		.s_hresp, .waits);
	// ----
	// helpers
	// ----
	task automatic chk(input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// sample ready mid cycle, leave just after the taking edge
	task automatic wait_rdy(output logic [31:0] d);
		int n;
		n = 0;
		do begin
			@(negedge ref_clk);
			d = m_hrdata;
			n++;
		end while (m_hready !== 1'h1 && n < 20);
		chk({31'h0, m_hready}, 32'h1);
		@(posedge ref_clk);
		#1;
	endtask
	// one transfer: address phase, then data phase
	task automatic xfer(input logic [31:0] a, input logic w,
		input logic [2:0] sz, input logic [31:0] wd);
		m_htrans = 2'h2;
		m_haddr = a;
		m_hwrite = w;
		m_hsize = sz;
		m_hprot = 4'h3;
		wait_rdy(rd);
		// idle phase, so the recirculated fields must be the captured ones
		m_htrans = 2'h0;
		m_haddr = 32'h00000000;
		m_hsize = 3'h0;
		m_hprot = 4'h0;
		m_hwdata = wd;
		wait_rdy(rd);
	endtask
	// ----
	// scenarios
	// ----
	// word insert, b=4 w=3 (bit 19 set), slave adds two waits
	task automatic t_insert;
		dbfu_slave_model_inst.mem[4] = 32'h12345678;
		waits = 4'h2;
		xfer(32'h52180010, 1'h1, 3'h2, 32'h000000A0);
		chk(dbfu_slave_model_inst.mem[4], 32'h123456A8);
	endtask
	// byte insert running past the container top
	task automatic t_byte;
		dbfu_slave_model_inst.mem[5] = 32'h0;
		waits = 4'h0;
		xfer(32'h53100014, 1'h1, 3'h0, 32'hFFFFFFFF);
		chk(dbfu_slave_model_inst.mem[5], 32'hC0C0C0C0);
	endtask
	// halfword single-bit insert, upper lane, stray bit 27 set
	task automatic t_half;
		dbfu_slave_model_inst.mem[8] = 32'h00000000;
		xfer(32'h5A800022, 1'h1, 3'h1, 32'hFFFFFFFF);
		chk(dbfu_slave_model_inst.mem[8], 32'h00200020);
	endtask
	// clear then set of bit 9, old bit returned
	task automatic t_bits;
		for (int op = 2; op < 4; op++) begin
			dbfu_slave_model_inst.mem[6] = op == 2 ? 32'h200 : 32'h0;
			xfer(32'h40000018 | op << 26 | 9 << 21, 1'h0, 3'h2, 32'h0);
			chk(rd, op == 2);
			chk(dbfu_slave_model_inst.mem[6], op == 2 ? 0 : 32'h200);
		end
	endtask
	// extract eight bits at bit 8, memory left alone
	task automatic t_extract;
		dbfu_slave_model_inst.mem[7] = 32'hCAFEBABE;
		waits = 4'h1;
		xfer(32'h5438001C, 1'h0, 3'h2, 32'h0);
		chk(rd, 32'hBA);
		chk(dbfu_slave_model_inst.mem[7], 32'hCAFEBABE);
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		#1;
		rst_b = 1'h1;
		t_insert;
		t_byte;
		t_half;
		t_bits;
		t_extract;
		report_and_stop;
	end
	// hang guard
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			num_errors++;
			report_and_stop;
		end
	end
endmodule
